// ---- logic/mmp_port.sv ----
// parallel memory master port with apb register access
module mmp_port (
   // clock and reset
   input  wire logic        clk_sys,
   input  wire logic        srst,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic             pready,
   output logic [31:0]      prdata,
   output logic             pslverr,
   // memory bus
   output logic [15:0]      addr_out,
   output logic [15:0]      addr_oe,
   output logic [7:0]       data_out,
   output logic             data_oe,
   input  wire logic [7:0]  data_in,
   output logic             write_strobe_pin,
   output logic             read_strobe_pin,
   // completion event
   output logic             access_done
);
   typedef struct packed {
      logic [15:0]         ctrl;
      logic [15:0]         mode_cfg;
      logic [15:0]         pin_en;
      logic [15:0]         addr;
      logic [7:0]          data;
      mmp_pkg::mmp_state_e fsm;
      logic                busy;
      logic                is_wr;
      logic                done;
      logic                pready;
      logic                pslverr;
      logic [31:0]         prdata;
      logic [15:0]         a_out;
      logic [15:0]         a_oe;
      logic [7:0]          d_out;
      logic                d_oe;
      logic                wr_pin;
      logic                rd_pin;
   } mmp_top_s;

   mmp_top_s   st;
   mmp_top_s   next_st;
   logic       cnt_load;
   logic [5:0] cnt_val;
   logic       cnt_last;
   logic       en;
   logic [1:0] mux;
   logic       wait_en;
   logic [5:0] setup_len;
   logic [5:0] width_len;
   logic [5:0] hold_len;
   logic       wr_acc;
   logic       rd_acc;
   logic       start;
   logic       start_wr;
   logic       finish;

   // ------------------------------------------------------------
   // phase length counter
   // ------------------------------------------------------------
   mmp_wait_cnt u_wait (
      .clk_sys  (clk_sys),
      .srst     (srst),
      .load     (cnt_load),
      .load_val (cnt_val),
      .last     (cnt_last)
   );

   // ------------------------------------------------------------
   // configuration fields
   // ------------------------------------------------------------
   // phase lengths in clock cycles, each at least one instruction cycle
   always_comb begin
      en = st.ctrl[mmp_pkg::CTRL_EN_POS];
      mux = st.ctrl[mmp_pkg::CTRL_MUX_POS +: 2];
      wait_en = st.mode_cfg[mmp_pkg::MODE_WAIT_EN_POS];
      setup_len = 6'({2'h0, st.mode_cfg[mmp_pkg::MODE_SETUP_POS +: 2]} + 4'h1)
                  * 6'(mmp_pkg::TCY_CLKS); // [RL21]
      hold_len = 6'({2'h0, st.mode_cfg[mmp_pkg::MODE_HOLD_POS +: 2]} + 4'h1)
                 * 6'(mmp_pkg::TCY_CLKS); // [RL21]
      width_len = 6'(st.mode_cfg[mmp_pkg::MODE_WIDTH_POS +: 4]) * 6'(mmp_pkg::TCY_CLKS); // [RL22]
      if (width_len == 6'h00) begin
         width_len = 6'(mmp_pkg::TCY_CLKS);
      end
      // with waits off each phase is a single instruction cycle
      if (!wait_en) begin
         setup_len = 6'(mmp_pkg::TCY_CLKS);
         width_len = 6'(mmp_pkg::TCY_CLKS);
         hold_len = 6'(mmp_pkg::TCY_CLKS);
      end
   end

   // ------------------------------------------------------------
   // next state: bus slave, sequencer, pins
   // ------------------------------------------------------------
   always_comb begin
      next_st = st;
      next_st.done = 1'b0;
      cnt_load = 1'b0;
      cnt_val = 6'h01;
      start = 1'b0;
      start_wr = 1'b0;
      finish = 1'b0;
      // apb: answer prepared during the setup cycle, one access cycle
      next_st.pready = psel & ~penable & ~st.pready;
      wr_acc = psel & penable & st.pready & pwrite;
      rd_acc = psel & penable & st.pready & ~pwrite;
      if (psel && !penable) begin
         next_st.pslverr = 1'b0;
         next_st.prdata = 32'h0000_0000;
         case (paddr)
            mmp_pkg::OFS_CTRL: next_st.prdata = {16'h0000, st.ctrl};
            mmp_pkg::OFS_MODE: next_st.prdata = {16'h0000, st.busy, st.mode_cfg[14:0]}; // [RL17]
            mmp_pkg::OFS_PINEN: next_st.prdata = {16'h0000, st.pin_en};
            mmp_pkg::OFS_ADDR: next_st.prdata = {16'h0000, st.addr};
            mmp_pkg::OFS_DATA: next_st.prdata = {24'h00_0000, st.data};
            default: next_st.pslverr = 1'b1;
         endcase
      end
      // register writes; data write launches a bus write
      if (wr_acc) begin
         case (paddr)
            mmp_pkg::OFS_CTRL: next_st.ctrl = pwdata[15:0]; // [RL2]
            mmp_pkg::OFS_MODE: next_st.mode_cfg = pwdata[15:0] & mmp_pkg::MODE_RW_MASK;
            mmp_pkg::OFS_PINEN: next_st.pin_en = pwdata[15:0];
            mmp_pkg::OFS_ADDR: next_st.addr = pwdata[15:0]; // [RL10]
            mmp_pkg::OFS_DATA: begin
               if (!st.busy && en) begin
                  next_st.data = pwdata[7:0];
                  start = 1'b1; // [RL23]
                  start_wr = 1'b1;
               end
            end
            default: ;
         endcase
      end
      // a data read returns the last byte and launches a bus read
      if (rd_acc && paddr == mmp_pkg::OFS_DATA && !st.busy && en) begin
         start = 1'b1;
      end
      // access sequencer
      unique case (st.fsm)
         mmp_pkg::ST_IDLE: begin
            if (start) begin
               next_st.busy = 1'b1; // [RL17]
               next_st.is_wr = start_wr;
               cnt_load = 1'b1;
               if (mux != mmp_pkg::MUX_NONE) begin
                  next_st.fsm = mmp_pkg::ST_ADDRL; // [RL19]
                  cnt_val = setup_len;
               end else if (wait_en) begin
                  next_st.fsm = mmp_pkg::ST_SETUP; // [RL18]
                  cnt_val = setup_len;
               end else begin
                  next_st.fsm = mmp_pkg::ST_STROBE; // [RL4]
                  cnt_val = width_len;
               end
            end
         end
         mmp_pkg::ST_ADDRL: begin
            if (cnt_last) begin
               cnt_load = 1'b1;
               if (mux == mmp_pkg::MUX_FULL) begin
                  next_st.fsm = mmp_pkg::ST_ADDRH;
                  cnt_val = setup_len;
               end else begin
                  next_st.fsm = mmp_pkg::ST_STROBE; // [RL9]
                  cnt_val = width_len;
               end
            end
         end
         mmp_pkg::ST_ADDRH, mmp_pkg::ST_SETUP: begin
            if (cnt_last) begin
               cnt_load = 1'b1;
               next_st.fsm = mmp_pkg::ST_STROBE;
               cnt_val = width_len;
            end
         end
         mmp_pkg::ST_STROBE: begin
            if (cnt_last) begin
               if (!st.is_wr) begin
                  next_st.data = data_in; // [RL23]
               end
               if (wait_en) begin
                  cnt_load = 1'b1;
                  next_st.fsm = mmp_pkg::ST_HOLD; // [RL18]
                  cnt_val = hold_len;
               end else begin
                  finish = 1'b1;
               end
            end
         end
         mmp_pkg::ST_HOLD: begin
            finish = cnt_last;
         end
         default: begin
            next_st.fsm = mmp_pkg::ST_IDLE;
            next_st.busy = 1'b0;
         end
      endcase
      // completion: event, busy release and address step
      if (finish) begin
         next_st.fsm = mmp_pkg::ST_IDLE;
         next_st.busy = 1'b0;
         next_st.done = st.mode_cfg[mmp_pkg::MODE_IRQ_EN_POS]; // [RL17]
         if (st.mode_cfg[mmp_pkg::MODE_INC_POS +: 2] == mmp_pkg::INC_UP) begin
            next_st.addr[14:0] = st.addr[14:0] + 15'h0001; // [RL16]
         end else if (st.mode_cfg[mmp_pkg::MODE_INC_POS +: 2] == mmp_pkg::INC_DOWN) begin
            next_st.addr[14:0] = st.addr[14:0] - 15'h0001; // [RL16]
         end
      end
      // pins follow the next state so that they leave flip-flops
      next_st.a_out = next_st.addr; // [RL3] [RL6] [RL11]
      next_st.a_out[mmp_pkg::ADDR_CS2_POS] = (next_st.busy && next_st.addr[mmp_pkg::ADDR_CS2_POS])
                                              ? st.ctrl[mmp_pkg::CTRL_CS_POL_POS]
                                              : ~st.ctrl[mmp_pkg::CTRL_CS_POL_POS]; // [RL12]
      if (mux != mmp_pkg::MUX_NONE) begin
         next_st.a_out[mmp_pkg::PIN_LATCH_LO] = (next_st.fsm == mmp_pkg::ST_ADDRL)
                                                ? st.ctrl[mmp_pkg::CTRL_ALE_POL_POS]
                                                : ~st.ctrl[mmp_pkg::CTRL_ALE_POL_POS]; // [RL7] [RL13]
      end
      if (mux == mmp_pkg::MUX_FULL) begin
         next_st.a_out[mmp_pkg::PIN_LATCH_HI] = (next_st.fsm == mmp_pkg::ST_ADDRH)
                                                ? st.ctrl[mmp_pkg::CTRL_ALE_POL_POS]
                                                : ~st.ctrl[mmp_pkg::CTRL_ALE_POL_POS];
      end
      next_st.a_oe = en ? next_st.pin_en : 16'h0000; // [RL1] [RL8] [RL20] [RL14]
      // shared data pins: address phases, then the byte being written
      next_st.d_oe = 1'b0;
      next_st.d_out = next_st.data;
      if (next_st.fsm == mmp_pkg::ST_ADDRL) begin
         next_st.d_oe = 1'b1;
         next_st.d_out = next_st.addr[7:0]; // [RL5]
      end else if (next_st.fsm == mmp_pkg::ST_ADDRH) begin
         next_st.d_oe = 1'b1;
         next_st.d_out = {1'b0, next_st.addr[14:8]};
      end else if (next_st.fsm != mmp_pkg::ST_IDLE && next_st.is_wr) begin
         next_st.d_oe = 1'b1;
      end
      // separate strobes, each with its own polarity
      next_st.wr_pin = (next_st.fsm == mmp_pkg::ST_STROBE && next_st.is_wr)
                       ? st.ctrl[mmp_pkg::CTRL_WR_POL_POS]
                       : ~st.ctrl[mmp_pkg::CTRL_WR_POL_POS]; // [RL15]
      next_st.rd_pin = (next_st.fsm == mmp_pkg::ST_STROBE && !next_st.is_wr)
                       ? st.ctrl[mmp_pkg::CTRL_RD_POL_POS]
                       : ~st.ctrl[mmp_pkg::CTRL_RD_POL_POS]; // [RL15]
   end

   // ------------------------------------------------------------
   // state register
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         st <= '0;
         st.ctrl <= mmp_pkg::CTRL_RST;
         st.mode_cfg <= mmp_pkg::MODE_RST;
         st.pin_en <= mmp_pkg::PINEN_RST;
         st.addr <= mmp_pkg::ADDR_RST;
         st.fsm <= mmp_pkg::ST_IDLE;
         st.a_out <= 16'h8000; // chip select idle high
         st.wr_pin <= 1'b1;
         st.rd_pin <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   // outputs straight from the state register
   assign pready = st.pready;
   assign prdata = st.prdata;
   assign pslverr = st.pslverr;
   assign addr_out = st.a_out;
   assign addr_oe = st.a_oe;
   assign data_out = st.d_out;
   assign data_oe = st.d_oe;
   assign write_strobe_pin = st.wr_pin;
   assign read_strobe_pin = st.rd_pin;
   assign access_done = st.done;

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (srst);

   strobe_excl_a: assert property ( // [RL15]
      !(st.wr_pin == st.ctrl[mmp_pkg::CTRL_WR_POL_POS]
        && st.rd_pin == st.ctrl[mmp_pkg::CTRL_RD_POL_POS]))
      else $error("read and write strobes active together");
   demux_one_a: assert property ( // [RL4]
      $rose(st.busy) && mux == mmp_pkg::MUX_NONE && !wait_en |-> ##1 !st.busy)
      else $error("separated access not done in one cycle");
   partial_two_a: assert property ( // [RL9]
      $rose(st.busy) && mux == mmp_pkg::MUX_LOW && !wait_en |-> st.busy ##2 !st.busy)
      else $error("partial mux access not two cycles");
   low_latch_a: assert property ( // [RL5]
      st.fsm == mmp_pkg::ST_ADDRL |-> st.d_oe && st.d_out == st.addr[7:0]
         && st.a_out[0] == st.ctrl[mmp_pkg::CTRL_ALE_POL_POS])
      else $error("low address phase wrong on data pins");
   upper_addr_a: assert property ( // [RL6]
      st.busy && mux == mmp_pkg::MUX_LOW |-> st.a_out[14:8] == st.addr[14:8])
      else $error("upper address outputs wrong");
   cs_active_a: assert property ( // [RL10]
      st.busy && st.addr[15] |-> st.a_out[15] == st.ctrl[mmp_pkg::CTRL_CS_POL_POS])
      else $error("second chip select not active");
   pin_gate_a: assert property ( // [RL20]
      st.a_oe == ($past(en) ? st.pin_en : 16'h0000))
      else $error("pin enables not applied");
   addr_step_a: assert property ( // [RL16]
      $fell(st.busy) && st.mode_cfg[12:11] == mmp_pkg::INC_UP
      |-> st.addr[14:0] == $past(st.addr[14:0]) + 15'h0001)
      else $error("address not incremented");
   wr_data_a: assert property ( // [RL23]
      st.fsm == mmp_pkg::ST_STROBE && st.is_wr |-> st.d_oe && st.d_out == st.data)
      else $error("write byte not on data pins");
   high_latch_a: assert property ( // [RL19]
      st.fsm == mmp_pkg::ST_ADDRH |-> st.d_oe && st.d_out == {1'b0, st.addr[14:8]}
         && st.a_out[1] == st.ctrl[mmp_pkg::CTRL_ALE_POL_POS])
      else $error("high address phase wrong on data pins");
   latch_idle_a: assert property ( // [RL7]
      mux != mmp_pkg::MUX_NONE && st.fsm != mmp_pkg::ST_ADDRL && $stable(st.ctrl)
      |-> st.a_out[0] != st.ctrl[mmp_pkg::CTRL_ALE_POL_POS])
      else $error("low latch strobe active outside address phase");
   cs_idle_a: assert property ( // [RL12]
      !st.busy && $stable(st.ctrl) |-> st.a_out[15] != st.ctrl[mmp_pkg::CTRL_CS_POL_POS])
      else $error("second chip select active while idle");
   rd_capture_a: assert property ( // [RL23]
      st.fsm == mmp_pkg::ST_STROBE && !st.is_wr && cnt_last |=> st.data == $past(data_in))
      else $error("read byte not captured");
   done_idle_a: assert property ( // [RL17]
      st.done |-> !st.busy && st.fsm == mmp_pkg::ST_IDLE)
      else $error("completion event while busy");

   demux_wr_c: cover property ($rose(st.busy) && st.is_wr && mux == mmp_pkg::MUX_NONE);
   partial_rd_c: cover property ($rose(st.busy) && !st.is_wr && mux == mmp_pkg::MUX_LOW);
   full_mux_c: cover property (st.fsm == mmp_pkg::ST_ADDRH);
   hold_wait_c: cover property (st.fsm == mmp_pkg::ST_HOLD ##1 st.done);
endmodule

// ---- logic/mmp_pkg.sv ----
// constants, types and register map of the parallel memory master port
//
// Summary of operation
// RL1 - Chip select in use leaves fifteen address outputs
// RL2 - Three bus arrangements selectable in control register
// RL3 - Separated arrangement: every address, data bit own pin
// RL4 - Separated arrangement access completes in one cycle
// RL5 - Partial mux: low address byte on data pins first
// RL6 - Partial mux: upper address on outputs 14:8
// RL7 - Partial mux: address output zero is latch strobe
// RL8 - Partial mux: address outputs 7:1 freed
// RL9 - Partial mux access takes two cycles
// RL10 - Address bit 15 enables second chip select
// RL11 - First select is address 14, second selects
// RL12 - Chip select and strobes active low as configured
// RL13 - Latch strobe active high for transparent latch
// RL14 - Separated arrangement: latch polarity has no effect
// RL15 - Bus master, 8-bit data, separate read/write strobes
// RL16 - Address increments, decrements or holds after access
// RL17 - Busy bit; completion event optionally signalled
// RL18 - Programmable setup, strobe width and hold
// RL19 - Multiplexed: address phase length replaces setup
// RL20 - Pin enables gate each address output
// RL21 - Setup and hold span one to four cycles
// RL22 - Strobe width spans one to fifteen cycles
// RL23 - Data write starts bus write; read data captured
package mmp_pkg;
   // ------------------------------------------------------------
   // register offsets (byte addresses)
   // ------------------------------------------------------------
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_MODE = 8'h04;
   localparam logic [7:0] OFS_PINEN = 8'h08;
   localparam logic [7:0] OFS_ADDR = 8'h0C;
   localparam logic [7:0] OFS_DATA = 8'h10;
   // ------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------
   localparam int CTRL_EN_POS = 15;
   localparam int CTRL_MUX_POS = 11;
   localparam int CTRL_ALE_POL_POS = 5;
   localparam int CTRL_CS_POL_POS = 4;
   localparam int CTRL_WR_POL_POS = 1;
   localparam int CTRL_RD_POL_POS = 0;
   localparam int MODE_BUSY_POS = 15;
   localparam int MODE_IRQ_EN_POS = 14;
   localparam int MODE_INC_POS = 11;
   localparam int MODE_WAIT_EN_POS = 10;
   localparam int MODE_SETUP_POS = 6;
   localparam int MODE_WIDTH_POS = 2;
   localparam int MODE_HOLD_POS = 0;
   localparam int ADDR_CS2_POS = 15;
   localparam int PIN_LATCH_LO = 0;
   localparam int PIN_LATCH_HI = 1;
   // ------------------------------------------------------------
   // reset values and encodings
   // ------------------------------------------------------------
   localparam logic [15:0] CTRL_RST = 16'h0020;
   localparam logic [15:0] MODE_RST = 16'h0000;
   localparam logic [15:0] PINEN_RST = 16'h0000;
   localparam logic [15:0] ADDR_RST = 16'h0000;
   localparam logic [15:0] MODE_RW_MASK = 16'h7FFF;
   localparam logic [1:0] MUX_NONE = 2'h0;
   localparam logic [1:0] MUX_LOW = 2'h1;
   localparam logic [1:0] MUX_FULL = 2'h2;
   localparam logic [1:0] INC_UP = 2'h1;
   localparam logic [1:0] INC_DOWN = 2'h2;
   // ------------------------------------------------------------
   // timing: one instruction cycle in clock cycles
   // ------------------------------------------------------------
   localparam int CLK_NS = 100;
   localparam int TCY_NS = 100;
   localparam logic [3:0] TCY_CLKS = 4'((TCY_NS + CLK_NS - 1) / CLK_NS);
   // ------------------------------------------------------------
   // access sequencer states
   // ------------------------------------------------------------
   typedef enum logic [5:0] {
      ST_IDLE   = 6'h01,
      ST_ADDRL  = 6'h02,
      ST_ADDRH  = 6'h04,
      ST_SETUP  = 6'h08,
      ST_STROBE = 6'h10,
      ST_HOLD   = 6'h20
   } mmp_state_e;
endpackage

// ---- logic/mmp_wait_cnt.sv ----
// phase length counter of the access sequencer
module mmp_wait_cnt (
   // clock and reset
   input  wire logic       clk_sys,
   input  wire logic       srst,
   // phase load
   input  wire logic       load,
   input  wire logic [5:0] load_val,
   // current phase ends this cycle
   output logic            last
);
   typedef struct packed {
      logic [5:0] cnt;
   } mmp_cnt_s;

   mmp_cnt_s st;
   mmp_cnt_s next_st;

   // load a new length or count down
   always_comb begin
      next_st = st;
      if (load) begin
         next_st.cnt = load_val;
      end else if (st.cnt != 6'h00) begin
         next_st.cnt = st.cnt - 6'h01;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign last = (st.cnt <= 6'h01);
endmodule

// ---- dv/mmp_mem_model.sv ----
// byte-wide external memory behind transparent address latches
module mmp_mem_model (
   // clock
   input  wire logic        clk_sys,
   // bus arrangement and read access delay in cycles
   input  wire logic [1:0]  mux,
   input  wire logic [3:0]  rd_lat,
   // memory bus
   input  wire logic [15:0] addr_out,
   input  wire logic [7:0]  data_out,
   input  wire logic        data_oe,
   input  wire logic        write_strobe_pin,
   input  wire logic        read_strobe_pin,
   output logic [7:0]       data_in
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0]  mem [0:32767];
   logic [7:0]  lat_lo;
   logic [7:0]  lat_hi;
   logic [14:0] a;
   logic [7:0]  last = 8'h00;
   logic [3:0]  rcnt = 4'h0;
   logic        sel;
   // latches take the shared pins at each clock while their strobe is high,
   // so the strobe falling with the data change cannot race the capture
   always_ff @(posedge clk_sys) begin
      if (addr_out[0]) lat_lo <= data_out;
      if (addr_out[1]) lat_hi <= data_out;
   end
   // address from pins or latches, chip select active low
   assign a = (mux == 2'h0) ? addr_out[14:0] :
              (mux == 2'h1) ? {addr_out[14:8], lat_lo} : {lat_hi[6:0], lat_lo};
   assign sel = !addr_out[15];
   // write on any clock of the low write strobe, count read strobe cycles
   always_ff @(posedge clk_sys) begin
      if (sel && !write_strobe_pin && data_oe) mem[a] <= data_out;
      rcnt <= read_strobe_pin ? 4'h0 : rcnt + 4'h1;
      last <= data_in;
   end
   // data only after the access delay, a toggling pattern when released
   assign data_in = (sel && !read_strobe_pin && rcnt >= rd_lat) ? mem[a] : ~last;
endmodule

// ---- dv/parallel_memory_master_port_tb.sv ----
// self-checking bench for the parallel memory master port
`define CHK(g, e) \
   begin \
      cmp_count++; \
      if ((g) !== (e)) begin \
         fail_count++; \
         $display("[FAIL] t=%0t got=%h exp=%h", $time, (g), (e)); \
      end \
   end
module parallel_memory_master_port_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_sys, srst, psel, penable, pwrite, pready, pslverr, data_oe, access_done;
   logic [7:0]  paddr, data_out, data_in;
   logic [31:0] pwdata, prdata;
   logic [15:0] addr_out, addr_oe, exp_a;
   logic        write_strobe_pin, read_strobe_pin;
   logic [1:0]  mux;
   logic [3:0]  rd_lat;
   int fail_count = 0, cmp_count = 0, n_str, n_ale, n_alh, n_oe, n_done;
   // -----------------------------------------------------------
   // design, memory and clock
   // -----------------------------------------------------------
   mmp_port mmp_port_i (.clk_sys(clk_sys), .srst(srst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
      .pslverr(pslverr), .addr_out(addr_out), .addr_oe(addr_oe), .data_out(data_out),
      .data_oe(data_oe), .data_in(data_in), .write_strobe_pin(write_strobe_pin),
      .read_strobe_pin(read_strobe_pin), .access_done(access_done));
   mmp_mem_model mmp_mem_model_i (.clk_sys(clk_sys), .mux(mux), .rd_lat(rd_lat),
      .addr_out(addr_out), .data_out(data_out), .data_oe(data_oe),
      .write_strobe_pin(write_strobe_pin), .read_strobe_pin(read_strobe_pin), .data_in(data_in));
   always #50 clk_sys = ~clk_sys;
   // -----------------------------------------------------------
   // bus monitor: phase counts and pin contents
   // -----------------------------------------------------------
   always @(posedge clk_sys) begin
      if (!write_strobe_pin || !read_strobe_pin) begin
         n_str++;
         if (mux == 2'h0) `CHK(addr_out, {1'b0, exp_a[14:0]})
         if (mux == 2'h1) `CHK(addr_out[14:8], exp_a[14:8])
      end
      if (mux != 2'h0 && addr_out[0]) begin
         n_ale++;
         `CHK(data_out, exp_a[7:0])
      end
      if (mux == 2'h2 && addr_out[1]) begin
         n_alh++;
         `CHK(data_out, {1'b0, exp_a[14:8]})
      end
      if (data_oe) n_oe++;
      if (access_done) n_done++;
   end
   // -----------------------------------------------------------
   // apb master and access helpers
   // -----------------------------------------------------------
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
      int n;
      @(posedge clk_sys);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk_sys);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) fail_count++;
      q = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      logic [31:0] q;
      logic        e;
      apb(1'b1, a, {16'h0, d}, q, e);
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] q);
      logic e;
      apb(1'b0, a, 32'h0, q, e);
   endtask
   // poll the busy flag until the access is over
   task automatic wait_idle();
      logic [31:0] q;
      int          n;
      n = 0;
      do begin
         rd(mmp_pkg::OFS_MODE, q);
         n++;
      end while (q[15] !== 1'b0 && n < 100);
      if (n >= 100) fail_count++;
   endtask
   task automatic xfer(input logic w, input logic [7:0] d, output logic [7:0] q);
      logic [31:0] r;
      logic        e;
      n_str = 0;
      n_ale = 0;
      n_alh = 0;
      n_oe = 0;
      n_done = 0;
      apb(w, mmp_pkg::OFS_DATA, {24'h0, d}, r, e);
      q = r[7:0];
      wait_idle();
   endtask
   // a data read returns the byte of the access before it
   task automatic rd_mem(output logic [7:0] q);
      xfer(1'b0, 8'h00, q);
      xfer(1'b0, 8'h00, q);
   endtask
   task automatic cfg(input logic [1:0] m, input logic [15:0] c, input logic [15:0] md,
                      input logic [15:0] p, input logic [15:0] a);
      mux <= m;
      exp_a = a;
      wr(mmp_pkg::OFS_CTRL, c);
      wr(mmp_pkg::OFS_MODE, md);
      wr(mmp_pkg::OFS_PINEN, p);
      wr(mmp_pkg::OFS_ADDR, a);
   endtask
   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // watchdog well beyond the length of all tests
   initial begin
      #(20000 * 100);
      fail_count++;
      finish_test();
   end
   // -----------------------------------------------------------
   // test sequence
   // -----------------------------------------------------------
   initial begin
      logic [31:0] q;
      logic [7:0]  b;
      logic        e;
      logic [7:0]  ofs [4] = '{8'h00, 8'h04, 8'h08, 8'h0C};
      logic [15:0] rv [4] = '{mmp_pkg::CTRL_RST, 16'h0, 16'h0, 16'h0};
      logic [1:0]  stp [3] = '{2'h0, mmp_pkg::INC_UP, mmp_pkg::INC_DOWN};
      logic [15:0] dl [3] = '{16'h0000, 16'h0001, 16'hFFFF};
      {clk_sys, psel, penable, pwrite, paddr, pwdata, mux, rd_lat, exp_a} = '0;
      srst = 1'b1;
      repeat (5) @(posedge clk_sys);
      srst <= 1'b0;
      @(posedge clk_sys);
      `CHK({addr_out, write_strobe_pin, read_strobe_pin}, 18'h20003)
      foreach (ofs[i]) begin
         rd(ofs[i], q);
         `CHK(q, {16'h0, rv[i]})
      end
      apb(1'b0, 8'h40, 32'h0, q, e);
      `CHK({e, q}, 33'h100000000)
      wr(mmp_pkg::OFS_MODE, 16'hFFFF);
      rd(mmp_pkg::OFS_MODE, q);
      `CHK(q, {16'h0, mmp_pkg::MODE_RW_MASK})
      xfer(1'b1, 8'h11, b);
      `CHK(n_str + n_oe, 0)
      $display("test reset and registers done");
      for (int k = 0; k < 3; k++) begin
         cfg(2'h0, 16'h8000, {3'b010, stp[k], 11'h0}, 16'hFFFF, 16'h9230 + 16'(k * 16));
         `CHK(addr_oe, 16'hFFFF)
         xfer(1'b1, 8'hA0 + 8'(k), b);
         `CHK({n_str, n_oe, n_done}, {32'd1, 32'd1, 32'd1})
         rd(mmp_pkg::OFS_ADDR, q);
         `CHK(q[15:0], exp_a + dl[k])
      end
      cfg(2'h0, 16'h8000, 16'h0000, 16'hFFFF, 16'h9230);
      rd_mem(b);
      `CHK({b, n_str}, {8'hA0, 32'd1})
      $display("test separated done");
      cfg(2'h1, 16'h8820, 16'h4000, 16'hFF01, 16'hAA5C);
      `CHK(addr_oe, 16'hFF01)
      xfer(1'b1, 8'h5A, b);
      `CHK({n_ale, n_str}, {32'd1, 32'd1})
      cfg(2'h1, 16'h8820, 16'h4000, 16'hFF01, 16'h9230);
      rd_mem(b);
      `CHK(b, 8'hA0)
      cfg(2'h0, 16'h8000, 16'h0000, 16'hFFFF, 16'hAA5C);
      rd_mem(b);
      `CHK(b, 8'h5A)
      $display("test partial done");
      cfg(2'h2, 16'h9020, 16'h4448, 16'h8003, 16'hFE81);
      xfer(1'b1, 8'h3C, b);
      `CHK({n_ale, n_alh, n_str}, {32'd2, 32'd2, 32'd2})
      rd_mem(b);
      `CHK(b, 8'h3C)
      $display("test full done");
      cfg(2'h0, 16'h8000, 16'h04FF, 16'hFFFF, 16'h8F0F);
      rd_lat <= 4'd10;
      n_str = 0;
      n_oe = 0;
      wr(mmp_pkg::OFS_DATA, 16'h00C3);
      rd(mmp_pkg::OFS_MODE, q);
      `CHK(q[15], 1'b1)
      wait_idle();
      `CHK({n_str, n_oe}, {32'd15, 32'd23})
      rd_mem(b);
      `CHK(b, 8'hC3)
      $display("test wait states done");
      finish_test();
   end
endmodule
